// ===== bld_regbank.sv
`timescale 1ns/1ps
`default_nettype none
module bld_regbank #(
    parameter int         DUTY_DIV  = 1000,  // Pin sample prescale
    parameter int         DIM_DIV   = 4,     // Dimming counter prescale
    parameter logic [3:0] MAKER_ID  = 4'ha,  // Arbitrary value
    parameter logic [2:0] REV_ID    = 3'h2   // Arbitrary value
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    // SMBus pins
    input  wire logic                   scl_in,
    input  wire logic                   sda_in,
    output logic                        sda_out,
    output logic                        sda_oe,
    // Dimming input and fault sensors
    input  wire logic                   duty_input_pin,
    input  wire bld_pkg::bld_fault_in_t fault_in,
    // Power stage controls
    output logic                        dimming_pulse_signal,
    output logic                        converter_enable,
    output logic                        backlight_on_status
);
    import bld_pkg::*;

    // ****************************************************************
    // Pin conditioning
    // ****************************************************************
    localparam int NPIN = 13;
    localparam logic [NPIN-1:0] PIN_RST = 13'h1800;  // Bus lines idle high
    logic [NPIN-1:0] pin_raw;                          // Raw pin vector
    logic [NPIN-1:0] s1_r, s2_r, s3_r;                 // Sync stages
    logic [NPIN-1:0] pin_f_r;                          // Filtered levels
    assign pin_raw = {scl_in, sda_in, duty_input_pin, fault_in};

    // Three stages; a level counts only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_r[gi]    <= PIN_RST[gi];
                    s2_r[gi]    <= PIN_RST[gi];
                    s3_r[gi]    <= PIN_RST[gi];
                    pin_f_r[gi] <= PIN_RST[gi];
                end else begin
                    s1_r[gi] <= pin_raw[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    if (s2_r[gi] == s3_r[gi]) begin
                        pin_f_r[gi] <= s3_r[gi];
                    end
                end
            end
        end
    endgenerate

    bld_fault_in_t flt;                  // Filtered fault sensors
    logic          scl_f, sda_f, duty_f; // Filtered bus and duty pin
    assign flt    = bld_fault_in_t'(pin_f_r[9:0]);
    assign duty_f = pin_f_r[10];
    assign sda_f  = pin_f_r[11];
    assign scl_f  = pin_f_r[12];

    // ****************************************************************
    // Registers and live status
    // ****************************************************************
    logic [7:0] bright_r;                // Brightness code
    logic [2:0] ctrl_r;                  // Control bits 2..0
    logic       bl_on_r;                 // Backlight lit
    logic [7:0] on_cnt_r;                // Turn-on settle countdown
    logic [7:0] status;                  // Live fault/status view
    logic [7:0] id_val;                  // Identification value
    logic       led_any, led_multi;

    // Count of faulted LED channels
    function automatic logic [3:0] pop8(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    assign led_any   = |flt.led_fault;
    assign led_multi = pop8(flt.led_fault) > 4'h1;
    // Live bits, never latched, so a read needs no clearing side effect
    assign status = {2'b00, led_multi, led_any, bl_on_r,
                     flt.input_overcurrent, flt.thermal_trip,
                     led_any | flt.input_overcurrent | flt.thermal_trip};
    assign id_val = {1'b1, MAKER_ID, REV_ID};

    // Register read decode, used for the first and any repeated byte;
    // every source is an argument so the continuous assignment tracks it
    function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] br,
                                            input logic [2:0] ct, input logic [7:0] st,
                                            input logic [7:0] id);
        if (a == BLD_OFF_BRIGHT) begin
            return br;
        end else if (a == BLD_OFF_CTRL) begin
            return {5'h00, ct};
        end else if (a == BLD_OFF_STATUS) begin
            return st;
        end else if (a == BLD_OFF_ID) begin
            return id;
        end else begin
            return 8'h00;
        end
    endfunction

    // ****************************************************************
    // SMBus target
    // ****************************************************************
    bld_smb_state_t sm_r;                // Transfer state
    logic [3:0]     bits_r;              // Bit counter
    logic [7:0]     shift_r;             // Shift register
    logic [7:0]     cmd_r;               // Command code
    logic [7:0]     wdata_r;             // Received data byte
    logic           wr_pend_r;           // Data byte acked, awaiting stop
    logic           drive_r;             // Pull SDA low
    logic           rd_r;                // Read direction
    logic           scl_q, sda_q;        // Previous filtered levels
    logic           scl_rise, scl_fall, start_c, stop_c, addr_hit;
    logic           wr_stb;              // Completed write-byte
    logic [7:0]     rd_byte;

    assign scl_rise = scl_f & ~scl_q;
    assign scl_fall = ~scl_f & scl_q;
    assign start_c  = scl_f & scl_q & sda_q & ~sda_f;
    assign stop_c   = scl_f & scl_q & ~sda_q & sda_f;
    assign addr_hit = shift_r[7:1] == BLD_TARGET_ADDR;
    assign wr_stb   = stop_c & wr_pend_r;
    assign rd_byte  = reg_read(cmd_r, bright_r, ctrl_r, status, id_val);
    // Open drain: only ever pull low
    assign sda_out  = 1'b0;
    assign sda_oe   = drive_r;

    // Edge history of the filtered bus lines
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    // Byte engine; start and stop override any bit in progress
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sm_r      <= SM_IDLE;
            bits_r    <= 4'h0;
            shift_r   <= 8'h00;
            cmd_r     <= 8'h00;
            wdata_r   <= 8'h00;
            wr_pend_r <= 1'b0;
            drive_r   <= 1'b0;
            rd_r      <= 1'b0;
        end else if (start_c) begin
            // Repeated start keeps the command code for read-byte
            sm_r      <= SM_ADDR;
            bits_r    <= 4'h0;
            drive_r   <= 1'b0;
            wr_pend_r <= 1'b0;
        end else if (stop_c) begin
            sm_r      <= SM_IDLE;
            drive_r   <= 1'b0;
            wr_pend_r <= 1'b0;
        end else if (scl_rise) begin
            if (sm_r == SM_ADDR || sm_r == SM_CMD || sm_r == SM_WDATA) begin
                shift_r <= {shift_r[6:0], sda_f};
                bits_r  <= bits_r + 4'h1;
            end else if (sm_r == SM_RACK && sda_f) begin
                sm_r <= SM_IDLE;                // Host refused more data
            end
        end else if (scl_fall) begin
            case (sm_r)
                SM_ADDR: begin
                    if (bits_r == 4'h8) begin
                        sm_r    <= addr_hit ? SM_ADDR_ACK : SM_IDLE;
                        drive_r <= addr_hit;
                        rd_r    <= shift_r[0];
                    end
                end
                SM_ADDR_ACK, SM_RACK: begin
                    bits_r <= 4'h0;
                    if (rd_r) begin
                        shift_r <= rd_byte;
                        drive_r <= ~rd_byte[7];
                        sm_r    <= SM_RDATA;
                    end else begin
                        drive_r <= 1'b0;
                        sm_r    <= SM_CMD;
                    end
                end
                SM_CMD: begin
                    if (bits_r == 4'h8) begin
                        cmd_r   <= shift_r;
                        drive_r <= 1'b1;
                        sm_r    <= SM_CMD_ACK;
                    end
                end
                SM_CMD_ACK: begin
                    drive_r <= 1'b0;
                    bits_r  <= 4'h0;
                    sm_r    <= SM_WDATA;
                end
                SM_WDATA: begin
                    if (bits_r == 4'h8) begin
                        wdata_r <= shift_r;
                        drive_r <= 1'b1;
                        sm_r    <= SM_WDATA_ACK;
                    end
                end
                SM_WDATA_ACK: begin
                    // Takes effect only when the stop arrives
                    drive_r   <= 1'b0;
                    wr_pend_r <= 1'b1;
                    sm_r      <= SM_IDLE;
                end
                SM_RDATA: begin
                    if (bits_r == 4'h7) begin
                        drive_r <= 1'b0;
                        sm_r    <= SM_RACK;
                    end else begin
                        shift_r <= {shift_r[6:0], 1'b0};
                        drive_r <= ~shift_r[6];
                        bits_r  <= bits_r + 4'h1;
                    end
                end
                default: begin
                    drive_r <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Register writes and backlight enable
    // ****************************************************************
    logic wr_bright, wr_ctrl, on_req;
    assign wr_bright = wr_stb & (cmd_r == BLD_OFF_BRIGHT) & ~ctrl_r[BLD_CTL_SRC];
    assign wr_ctrl   = wr_stb & (cmd_r == BLD_OFF_CTRL);
    assign on_req    = wr_ctrl & wdata_r[BLD_CTL_EN] & ~ctrl_r[BLD_CTL_EN];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bright_r <= BLD_RST_BRIGHT;
            ctrl_r   <= BLD_RST_CTRL;
        end else begin
            if (wr_bright) begin
                bright_r <= wdata_r;
            end
            if (wr_ctrl) begin
                ctrl_r <= wdata_r[2:0];
            end
        end
    end

    // Settle countdown before lighting; off needs no wait
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            on_cnt_r <= 8'h00;
            bl_on_r  <= 1'b0;
        end else begin
            if (on_req) begin
                on_cnt_r <= 8'(BLD_ON_DELAY_CYC);
            end else if (on_cnt_r != 8'h00) begin
                on_cnt_r <= on_cnt_r - 8'h01;
            end
            bl_on_r <= ctrl_r[BLD_CTL_EN] & (on_cnt_r == 8'h00) & ~on_req;
        end
    end

    // ****************************************************************
    // Pin duty measurement and duty selection
    // ****************************************************************
    logic [15:0] pre_r;                  // Sample prescaler
    logic [7:0]  win_r, hi_r;            // Window position, high count
    logic [7:0]  pin_duty_r;             // Last measured pin duty
    logic        tick;
    assign tick = pre_r == 16'(DUTY_DIV - 1);

    // 255 samples per window give one duty code per window
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r      <= 16'h0000;
            win_r      <= 8'h00;
            hi_r       <= 8'h00;
            pin_duty_r <= BLD_RST_PINDUTY;
        end else begin
            pre_r <= tick ? 16'h0000 : pre_r + 16'h0001;
            if (tick) begin
                win_r <= (win_r == 8'hfe) ? 8'h00 : win_r + 8'h01;
                hi_r  <= (win_r == 8'hfe) ? 8'h00 : hi_r + {7'h00, duty_f};
                if (win_r == 8'hfe) begin
                    pin_duty_r <= hi_r + {7'h00, duty_f};
                end
            end
        end
    end

    logic [15:0] prod;
    logic [7:0]  prod8, duty_sel, level;
    assign prod     = bright_r * pin_duty_r;
    assign prod8    = 8'(prod / 16'd255);
    assign duty_sel = ctrl_r[BLD_CTL_SRC]    ? pin_duty_r :
                      ctrl_r[BLD_CTL_INTERP] ? bright_r : prod8;
    // Floor keeps code 0x00 at the 7/256 minimum
    assign level    = (duty_sel < BLD_MIN_LEVEL) ? BLD_MIN_LEVEL : duty_sel;

    // ****************************************************************
    // Dimming pulse generator
    // ****************************************************************
    logic [7:0] dpre_r, dcnt_r;          // Prescaler, 256-step phase
    logic       run;
    assign run = bl_on_r & ~flt.thermal_trip;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dpre_r               <= 8'h00;
            dcnt_r               <= 8'h00;
            dimming_pulse_signal <= 1'b0;
            converter_enable     <= 1'b0;
        end else begin
            dpre_r <= (dpre_r == 8'(DIM_DIV - 1)) ? 8'h00 : dpre_r + 8'h01;
            if (dpre_r == 8'(DIM_DIV - 1)) begin
                dcnt_r <= dcnt_r + 8'h01;
            end
            dimming_pulse_signal <= run & (dcnt_r <= level);
            converter_enable     <= run;
        end
    end
    assign backlight_on_status = status[BLD_FS_BLON];

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence on_req_s;
        on_req ##1 ctrl_r[BLD_CTL_EN] [*2];
    endsequence
    bright_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_bright |=> bright_r == $past(wdata_r))
        else $error("brightness write not stored");
    bright_lock_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wr_stb && cmd_r == BLD_OFF_BRIGHT && ctrl_r[BLD_CTL_SRC]) |=> $stable(bright_r))
        else $error("brightness changed in pin mode");
    turn_on_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        on_req_s |-> ##[1:130] bl_on_r)
        else $error("backlight not lit in time");
    turn_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wr_ctrl && !wdata_r[BLD_CTL_EN]) |-> ##2 !bl_on_r ##1 !converter_enable)
        else $error("backlight not off at once");
    thermal_stop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        flt.thermal_trip |=> !dimming_pulse_signal && !converter_enable)
        else $error("outputs live during thermal trip");
    fault_bits_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (flt.led_fault != 8'h00) |-> status[BLD_FS_ONE] && status[BLD_FS_ANY]
            && (status[BLD_FS_MULTI] == ($countones(flt.led_fault) > 1)))
        else $error("channel fault bits wrong");
    pin_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ctrl_r[BLD_CTL_SRC] |-> duty_sel == pin_duty_r)
        else $error("pin mode not using pin duty");
    duty_floor_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        run && dcnt_r <= BLD_MIN_LEVEL |=> dimming_pulse_signal)
        else $error("minimum duty not kept");
    addr_ack_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sm_r == SM_ADDR && scl_fall && bits_r == 4'h8 && !start_c && !stop_c)
            |=> drive_r == $past(addr_hit))
        else $error("address acknowledge wrong");
endmodule
`default_nettype wire

// ===== bld_pkg.sv
// Behaviour
// - Brightness register at 0x00, eight bits read/write
// - SMBus-mode write sets the output brightness
// - 0xFF gives full duty, 0x00 about 2.7%
// - Brightness register resets to 0xFF
// - Pin-mode brightness writes change nothing
// - Brightness reads return the stored register value in every mode
// - Brightness has 256 equal steps; codes 0x00 to 0x06 all give the 7/256 floor here
// - Control 0x01: enable, source select, interpretation
// - Control bits 7..3 read zero, writes ignored
// - Enable write lights backlight within 10 ms
// - Disable write turns backlight off at once
// - Duty source decoded from control bits 1, 2
// - Control resets to 0x00: off, product mode
// - Status 0x02 read-only, resets 0, bits 7..6 zero
// - Status bit 0 ORs every fault
// - Bit 4 one or more channels, bit 5 two or more
// - Status bit 3 shows backlight on
// - Status bit 2 shows input overcurrent
// - Thermal trip sets bits 0,1 and stops outputs
// - ID 0x03 read-only: panel, maker, revision
// - Device answers target address 0b0101100
// - LED faults set channel bits and bit 0
// - Stays off until an SMBus turn-on
// - Product mode: normalised product, pin duty starts full
`default_nettype none
package bld_pkg;
    // ****************************************************************
    // Bus address and register offsets
    // ****************************************************************
    localparam logic [6:0] BLD_TARGET_ADDR = 7'h2c;
    localparam logic [7:0] BLD_OFF_BRIGHT  = 8'h00;
    localparam logic [7:0] BLD_OFF_CTRL    = 8'h01;
    localparam logic [7:0] BLD_OFF_STATUS  = 8'h02;
    localparam logic [7:0] BLD_OFF_ID      = 8'h03;
    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] BLD_RST_BRIGHT  = 8'hff;
    localparam logic [2:0] BLD_RST_CTRL    = 3'h0;
    localparam logic [7:0] BLD_RST_PINDUTY = 8'hff;
    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BLD_CTL_EN     = 0;
    localparam int BLD_CTL_SRC    = 1;
    localparam int BLD_CTL_INTERP = 2;
    localparam int BLD_FS_ANY     = 0;
    localparam int BLD_FS_THERM   = 1;
    localparam int BLD_FS_OC      = 2;
    localparam int BLD_FS_BLON    = 3;
    localparam int BLD_FS_ONE     = 4;
    localparam int BLD_FS_MULTI   = 5;
    localparam int BLD_ID_PANEL   = 7;
    localparam int BLD_ID_MAKER   = 3;
    // ****************************************************************
    // Timing and duty constants
    // ****************************************************************
    localparam int BLD_CLK_NS      = 8;
    localparam int BLD_ON_DELAY_NS = 1000;
    localparam int BLD_ON_DELAY_CYC = (BLD_ON_DELAY_NS + BLD_CLK_NS - 1) / BLD_CLK_NS;
    localparam logic [7:0] BLD_MIN_LEVEL = 8'h06;
    localparam logic [7:0] BLD_FULL      = 8'hff;
    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [7:0] led_fault;
        logic       thermal_trip;
        logic       input_overcurrent;
    } bld_fault_in_t;
    typedef enum logic [3:0] {
        SM_IDLE, SM_ADDR, SM_ADDR_ACK, SM_CMD, SM_CMD_ACK,
        SM_WDATA, SM_WDATA_ACK, SM_RDATA, SM_RACK
    } bld_smb_state_t;
endpackage
`default_nettype wire

// ===== bld_smb_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// SMBus host model: open drain, released SDA floats high
// ****************************************************************
module bld_smb_host (
    // Clock
    input  wire logic core_clk,
    // Wired SDA level
    input  wire logic sda_line,
    // Host pins
    output logic      scl_o,
    output logic      sda_pull
);
    import bld_pkg::*;
    // Bus idle at time zero
    initial begin
        scl_o = 1'b1;
        sda_pull = 1'b0;
    end
    // Half SCL period; long enough for the pin filters
    task automatic half();
        repeat (10) @(negedge core_clk);
    endtask
    // One bit out, wire level sampled late in SCL high
    task automatic bit_io(input logic b, output logic r);
        sda_pull = ~b;
        half();
        scl_o = 1'b1;
        half();
        r = sda_line;
        scl_o = 1'b0;
        half();
    endtask
    // Start or repeated start
    task automatic start();
        @(negedge core_clk);
        sda_pull = 1'b0;
        half();
        scl_o = 1'b1;
        half();
        sda_pull = 1'b1;
        half();
        scl_o = 1'b0;
        half();
    endtask
    // Stop; SDA rises while SCL is high
    task automatic stop();
        sda_pull = 1'b1;
        half();
        scl_o = 1'b1;
        half();
        sda_pull = 1'b0;
        half();
    endtask
    // Byte msb first, ninth bit released: ack in, or NACK out on reads
    task automatic byte_io(input logic [7:0] d, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(1'b1, a);
    endtask
    // Write byte; nak is high if any byte was refused
    task automatic wr(input logic [7:0] c, input logic [7:0] d, output logic nak);
        logic [7:0] r;
        logic       a0, a1, a2;
        start();
        byte_io({BLD_TARGET_ADDR, 1'b0}, r, a0);
        byte_io(c, r, a1);
        byte_io(d, r, a2);
        stop();
        nak = a0 | a1 | a2;
    endtask
    // Read byte with repeated start, NACK on the data byte
    task automatic rd(input logic [7:0] c, output logic [7:0] q, output logic nak);
        logic [7:0] r;
        logic       a0, a1, a2, a3;
        start();
        byte_io({BLD_TARGET_ADDR, 1'b0}, r, a0);
        byte_io(c, r, a1);
        start();
        byte_io({BLD_TARGET_ADDR, 1'b1}, r, a2);
        byte_io(8'hff, q, a3);
        stop();
        nak = a0 | a1 | a2;
    endtask
    // Address byte alone, then stop; nak is high if nobody answered
    task automatic probe(input logic [6:0] a, output logic nak);
        logic [7:0] r;
        start();
        byte_io({a, 1'b0}, r, nak);
        stop();
    endtask
endmodule
`default_nettype wire

// ===== backlight_dimming_register_bank_test.sv
`timescale 1ns/1ps
`default_nettype none
module backlight_dimming_register_bank_test;
    import bld_pkg::*;
    logic          core_clk = 1'b0;
    logic          rst_n    = 1'b0;
    logic          pin      = 1'b1;
    logic          scl, pull, sda_oe, sda_out, pulse, conv, blon, nak;
    logic [9:0]    flt      = 10'h000; // LED faults, thermal, overcurrent
    logic [7:0]    rv;
    int            n;
    int            num_errors   = 0;
    int            total_checks = 0;
    wire logic     sda = ~pull & (sda_oe ? sda_out : 1'b1); // Pull-up when nobody pulls
    // Fault sets and the status they must show with the backlight on
    logic [9:0]    fv[3] = '{10'h004, 10'h00c, 10'h001};
    logic [7:0]    sv[3] = '{8'h19, 8'h39, 8'h0d};
    always #4 core_clk = ~core_clk;
    bld_smb_host host (.core_clk(core_clk), .sda_line(sda), .scl_o(scl), .sda_pull(pull));
    // Short prescales keep the pin window and dimming period small
    bld_regbank #(.DUTY_DIV(4), .DIM_DIV(1)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .duty_input_pin(pin),
        .fault_in(flt), .dimming_pulse_signal(pulse),
        .converter_enable(conv), .backlight_on_status(blon));
    task automatic give_verdict();
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [8:0] got, input logic [8:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        host.wr(c, d, nak);
        check("write ack", {8'h00, nak}, 9'h000);
    endtask
    task automatic rd(input logic [7:0] c, input logic [7:0] e);
        host.rd(c, rv, nak);
        check("read ack", {8'h00, nak}, 9'h000);
        check("register", {1'b0, rv}, {1'b0, e});
    endtask
    // High cycles over one full 256-step dimming period
    task automatic duty(input logic [8:0] e);
        repeat (8) @(posedge core_clk);
        n = 0;
        repeat (256) @(negedge core_clk) n += int'(pulse);
        check("duty", n[8:0], e);
        @(negedge core_clk);
    endtask
    initial begin
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge core_clk);
        check("off at start", {8'h00, conv}, 9'h000);
        rd(BLD_OFF_BRIGHT, 8'hff);
        rd(BLD_OFF_CTRL, 8'h00);
        rd(BLD_OFF_STATUS, 8'h00);
        rd(BLD_OFF_ID, {1'b1, 4'ha, 3'h2});
        rd(8'h05, 8'h00);
        host.probe(7'h2d, nak);
        check("foreign address", {8'h00, nak}, 9'h001);
        wr(BLD_OFF_CTRL, 8'h05);
        n = 0;
        while (conv !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        check("turn on time", {8'h00, n <= 130}, 9'h001);
        if (n >= 200)
            give_verdict();
        rd(BLD_OFF_STATUS, 8'h08);
        check("lit status", {8'h00, blon}, 9'h001);
        wr(BLD_OFF_BRIGHT, 8'h00);
        duty(9'd7);
        wr(BLD_OFF_BRIGHT, 8'h80);
        duty(9'd129);
        rd(BLD_OFF_BRIGHT, 8'h80);
        wr(BLD_OFF_CTRL, 8'h03);
        duty(9'd256);
        wr(BLD_OFF_BRIGHT, 8'h10);
        rd(BLD_OFF_BRIGHT, 8'h80);
        wr(BLD_OFF_CTRL, 8'hff);
        rd(BLD_OFF_CTRL, 8'h07);
        wr(BLD_OFF_CTRL, 8'h01);
        duty(9'd129);
        pin = 1'b0;
        repeat (2100) @(negedge core_clk);
        duty(9'd7);
        for (int i = 0; i < 3; i++) begin
            flt = fv[i];
            repeat (8) @(negedge core_clk);
            rd(BLD_OFF_STATUS, sv[i]);
        end
        flt = 10'h000;
        rd(BLD_OFF_STATUS, 8'h08);
        flt = 10'h002;
        repeat (8) @(negedge core_clk);
        check("thermal stop", {7'h00, conv, pulse}, 9'h000);
        host.rd(BLD_OFF_STATUS, rv, nak);
        check("thermal bits", {1'b0, rv & 8'hf7}, 9'h003);
        flt = 10'h000;
        wr(BLD_OFF_CTRL, 8'h00);
        check("turn off", {7'h00, blon, conv}, 9'h000);
        give_verdict();
    end
endmodule
`default_nettype wire
